// ==== rtl/mwf_regs.svh ====
// register indices, field positions and reset values of the main window block
`ifndef MWF_REGS_SVH
`define MWF_REGS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define MWF_IDX_KEY_BLUE 10'h208
`define MWF_IDX_SA_LOW 10'h210
`define MWF_IDX_SA_HIGH 10'h212
`define MWF_IDX_SA_STATUS 10'h214
`define MWF_IDX_LINE_OFS 10'h216

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define MWF_KEY_W 8
`define MWF_SA_HIGH_W 3
`define MWF_LINE_OFS_W 12
`define MWF_LO_HDBL 12
`define MWF_LO_VDBL 13
`define MWF_OVL_MODE_ON 2'h3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MWF_RST_KEY 8'h00
`define MWF_RST_SA_LOW 16'h0000
`define MWF_RST_SA_HIGH 3'h0
`define MWF_RST_STATUS 1'h1
`define MWF_RST_LINE_OFS 14'h0000

`endif

// ==== rtl/mwf_pkg.sv ====
// types shared by the main window fetch configuration block
package mwf_pkg;

    // ----------------------------------------------------------------
    // enumerations
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MWF_R_NONE,
        MWF_R_KEY,
        MWF_R_SAL,
        MWF_R_SAH,
        MWF_R_STAT,
        MWF_R_LO
    } mwf_reg_e;

    typedef enum logic [2:0] {
        MWF_OVL_NONE,
        MWF_OVL_TRANSPARENT,
        MWF_OVL_AVERAGE,
        MWF_OVL_AND_KEY,
        MWF_OVL_OR_KEY,
        MWF_OVL_INVERT
    } mwf_ovl_e;

    typedef enum logic [1:0] {
        MWF_ROT_0,
        MWF_ROT_90,
        MWF_ROT_180,
        MWF_ROT_270
    } mwf_rot_e;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic transparent;
        logic average;
        logic and_key;
        logic or_key;
        logic invert;
    } mwf_ovl_en_s;

    typedef struct packed {
        logic [7:0] key_blue;
        logic [15:0] sa_low;
        logic [2:0] sa_high;
        logic [13:0] line_ofs;
        logic [18:0] fetch_addr;
        logic pending;
        logic status;
        logic [15:0] rdata;
        logic err;
    } mwf_state_s;

endpackage

// ==== rtl/mwf_main_window_fetch_config.sv ====
// main window fetch configuration registers with apb slave and frame latching
`include "mwf_regs.svh"

// Operation
// RULE1: highest priority overlay function wins alone
// RULE2: blue key only active in overlay mode
// RULE3: blue key held in low byte
// RULE4: software bit-replicates key under palette bypass
// RULE5: start address from low word plus three bits
// RULE6: upper register bit 2 resets to zero
// RULE7: software steps address by pixel size
// RULE8: status shows whether latest address used
// RULE9: status changes only after address change
// RULE10: double buffer status shows displayed buffer
// RULE11: status register read-only, resets to one
// RULE12: bit 13 doubles pixels vertically
// RULE13: bit 12 doubles pixels horizontally
// RULE14: software adjusts start address for rotation
// RULE15: same adjustment for horizontal doubling
// RULE16: line offset in low field
// RULE17: software programs offset as width times bpp/8
// RULE18: rotation field selects 0 to 270 degrees
// RULE19: start address latched only at frame start
module mwf_main_window_fetch_config
    import mwf_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // frame timing and display mode inputs
    input wire logic frame_start,
    input wire logic [1:0] overlay_window_mode,
    input wire logic double_buffer_en,
    input wire logic main_is_front,
    input wire logic show_back_buffer,
    input wire logic [1:0] rotation_sel,
    input wire mwf_ovl_en_s overlay_en,
    // display pipe outputs
    output logic [18:0] fetch_addr,
    output logic [11:0] line_offset,
    output logic pixel_double_h,
    output logic pixel_double_v,
    output logic [7:0] key_blue,
    output logic key_blue_active,
    output mwf_ovl_e overlay_function,
    output mwf_rot_e rotation
);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic mwf_reg_e decode(input logic [11:0] a);
        mwf_reg_e r;
        r = MWF_R_NONE;
        if (a[1:0] == 2'h0) begin
            unique case (a[11:2])
                `MWF_IDX_KEY_BLUE: r = MWF_R_KEY;
                `MWF_IDX_SA_LOW: r = MWF_R_SAL;
                `MWF_IDX_SA_HIGH: r = MWF_R_SAH;
                `MWF_IDX_SA_STATUS: r = MWF_R_STAT;
                `MWF_IDX_LINE_OFS: r = MWF_R_LO;
                default: r = MWF_R_NONE;
            endcase
        end
        return r;
    endfunction

    mwf_state_s st;
    mwf_state_s next_st;
    mwf_reg_e setup_reg;
    mwf_reg_e acc_reg;
    logic setup;
    logic wr;
    logic wr_sa;
    logic db_front;

    assign setup = psel && !penable;
    assign setup_reg = decode(paddr);
    assign acc_reg = decode(paddr);
    assign wr = psel && penable && pwrite;
    assign wr_sa = wr && (acc_reg == MWF_R_SAL || acc_reg == MWF_R_SAH);
    assign db_front = double_buffer_en && main_is_front;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        // read data is captured in setup so the access phase needs no wait
        if (setup) begin
            next_st.err = (setup_reg == MWF_R_NONE);
            unique case (setup_reg)
                MWF_R_KEY: next_st.rdata = {8'h00, st.key_blue};
                MWF_R_SAL: next_st.rdata = st.sa_low;
                MWF_R_SAH: next_st.rdata = {13'h0000, st.sa_high};
                MWF_R_STAT: next_st.rdata = {15'h0000, st.status};
                MWF_R_LO: next_st.rdata = {2'h0, st.line_ofs};
                MWF_R_NONE: next_st.rdata = 16'h0000;
            endcase
        end
        if (wr) begin
            unique case (acc_reg)
                MWF_R_KEY: next_st.key_blue = pwdata[7:0]; // [RULE3]
                MWF_R_SAL: next_st.sa_low = pwdata[15:0]; // [RULE5]
                MWF_R_SAH: next_st.sa_high = pwdata[2:0]; // [RULE5]
                MWF_R_LO: next_st.line_ofs = pwdata[13:0]; // [RULE16]
                // status is read-only: writes drop silently
                MWF_R_STAT: next_st.rdata = st.rdata; // [RULE11]
                MWF_R_NONE: next_st.rdata = st.rdata;
            endcase
        end
        // a write in the latch cycle keeps pending, so it is never lost
        if (frame_start) begin
            next_st.fetch_addr = {st.sa_high, st.sa_low}; // [RULE19]
            next_st.pending = 1'b0;
            if (db_front) begin
                next_st.status = !show_back_buffer; // [RULE10]
            end else if (st.pending) begin
                next_st.status = 1'b1; // [RULE8]
            end
        end
        if (wr_sa) begin
            next_st.pending = 1'b1;
            if (!db_front) begin
                next_st.status = 1'b0; // [RULE8] [RULE9]
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st.key_blue <= `MWF_RST_KEY;
            st.sa_low <= `MWF_RST_SA_LOW;
            st.sa_high <= `MWF_RST_SA_HIGH; // [RULE6]
            st.line_ofs <= `MWF_RST_LINE_OFS;
            st.fetch_addr <= 19'h00000;
            st.pending <= 1'b0;
            st.status <= `MWF_RST_STATUS; // [RULE11]
            st.rdata <= 16'h0000;
            st.err <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign pready = 1'b1;
    assign pslverr = psel && penable && st.err;
    assign prdata = {16'h0000, st.rdata};
    assign fetch_addr = st.fetch_addr;
    assign line_offset = st.line_ofs[`MWF_LINE_OFS_W-1:0]; // [RULE16]
    assign pixel_double_h = st.line_ofs[`MWF_LO_HDBL]; // [RULE13]
    assign pixel_double_v = st.line_ofs[`MWF_LO_VDBL]; // [RULE12]
    assign key_blue = st.key_blue;
    // outside overlay mode key_blue_active drops, but key_blue itself still reaches the mixer
    assign key_blue_active = (overlay_window_mode == `MWF_OVL_MODE_ON); // [RULE2]

    always_comb begin
        overlay_function = MWF_OVL_NONE;
        if (overlay_en.transparent && key_blue_active) begin
            overlay_function = MWF_OVL_TRANSPARENT; // [RULE1] [RULE2]
        end else if (overlay_en.average) begin
            overlay_function = MWF_OVL_AVERAGE; // [RULE1]
        end else if (overlay_en.and_key) begin
            overlay_function = MWF_OVL_AND_KEY;
        end else if (overlay_en.or_key) begin
            overlay_function = MWF_OVL_OR_KEY;
        end else if (overlay_en.invert) begin
            overlay_function = MWF_OVL_INVERT;
        end
    end

    always_comb begin
        unique case (rotation_sel)
            2'h0: rotation = MWF_ROT_0; // [RULE18]
            2'h1: rotation = MWF_ROT_90;
            2'h2: rotation = MWF_ROT_180;
            2'h3: rotation = MWF_ROT_270;
        endcase
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    sequence frame_tick;
        frame_start && !wr_sa;
    endsequence

    sequence addr_write;
        wr_sa && !db_front;
    endsequence

    sequence latch_due;
        st.pending && !db_front;
    endsequence

    prio_order_a: assert property ( // [RULE1]
        overlay_en.transparent && key_blue_active |-> overlay_function == MWF_OVL_TRANSPARENT)
        else $error("transparent key lost priority");
    prio_second_a: assert property ( // [RULE1]
        !overlay_en.transparent && overlay_en.average |-> overlay_function == MWF_OVL_AVERAGE)
        else $error("average key lost priority");
    key_gate_a: assert property ( // [RULE2]
        overlay_window_mode != `MWF_OVL_MODE_ON |-> overlay_function != MWF_OVL_TRANSPARENT)
        else $error("key used outside overlay mode");
    key_field_a: assert property ( // [RULE3]
        wr && acc_reg == MWF_R_KEY |=> key_blue == $past(pwdata[7:0]) && prdata[31:8] == 24'h0)
        else $error("blue key field wrong");
    addr_latch_a: assert property ( // [RULE19]
        frame_start |=> fetch_addr == $past({st.sa_high, st.sa_low}))
        else $error("start address not latched at frame");
    addr_hold_a: assert property ( // [RULE19]
        !frame_start |=> $stable(fetch_addr))
        else $error("start address changed mid frame");
    status_clear_a: assert property ( // [RULE8]
        latch_due ##0 frame_tick |=> st.status)
        else $error("status did not return after latch");
    status_low_a: assert property ( // [RULE8]
        addr_write |=> !st.status)
        else $error("status not cleared on address write");
    status_quiet_a: assert property ( // [RULE9]
        !frame_start && !wr_sa |=> $stable(st.status))
        else $error("status changed on its own");
    db_status_a: assert property ( // [RULE10]
        frame_start && db_front |=> st.status == !$past(show_back_buffer))
        else $error("double buffer status wrong");
    status_ro_a: assert property ( // [RULE11]
        wr && acc_reg == MWF_R_STAT && !frame_start |=> $stable(st.status))
        else $error("status register was writable");
    dbl_bits_a: assert property ( // [RULE12] [RULE13]
        wr && acc_reg == MWF_R_LO |=>
            pixel_double_v == $past(pwdata[13]) && pixel_double_h == $past(pwdata[12]))
        else $error("doubling enables not stored");
    rot_map_a: assert property ( // [RULE18]
        rotation_sel == 2'h3 |-> rotation == MWF_ROT_270)
        else $error("rotation decode wrong");

endmodule

// ==== testbench/mwf_main_window_fetch_config_tb.sv ====
// self-checking bench for the main window fetch configuration block
`include "mwf_regs.svh"
module mwf_main_window_fetch_config_tb
    import mwf_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clock = 0;
    logic sys_rst = 1;
    logic psel = 0, penable = 0, pwrite = 0, frame_start = 0;
    logic double_buffer_en = 0, main_is_front = 0, show_back_buffer = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, last_q;
    logic pready, pslverr, last_e;
    logic [1:0] overlay_window_mode = '0, rotation_sel = '0;
    mwf_ovl_en_s overlay_en = '0;
    logic [18:0] fetch_addr;
    logic [11:0] line_offset;
    logic pixel_double_h, pixel_double_v, key_blue_active;
    logic [7:0] key_blue;
    mwf_ovl_e overlay_function;
    mwf_rot_e rotation;
    int miscompares = 0;
    int check_count = 0;
    localparam logic [11:0] A_KEY = {`MWF_IDX_KEY_BLUE, 2'b00};
    localparam logic [11:0] A_SAL = {`MWF_IDX_SA_LOW, 2'b00};
    localparam logic [11:0] A_SAH = {`MWF_IDX_SA_HIGH, 2'b00};
    localparam logic [11:0] A_ST = {`MWF_IDX_SA_STATUS, 2'b00};
    localparam logic [11:0] A_LO = {`MWF_IDX_LINE_OFS, 2'b00};

    always #25 clock = ~clock;

    mwf_main_window_fetch_config DUT (
        .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .frame_start(frame_start), .overlay_window_mode(overlay_window_mode),
        .double_buffer_en(double_buffer_en), .main_is_front(main_is_front),
        .show_back_buffer(show_back_buffer), .rotation_sel(rotation_sel),
        .overlay_en(overlay_en), .fetch_addr(fetch_addr), .line_offset(line_offset),
        .pixel_double_h(pixel_double_h), .pixel_double_v(pixel_double_v),
        .key_blue(key_blue), .key_blue_active(key_blue_active),
        .overlay_function(overlay_function), .rotation(rotation)
    );

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic tally_and_finish();
        if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // entered right after a rising edge; leaves one idle cycle behind it
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1;
        for (n = 0; n < 20; n++) begin
            @(posedge clock);
            if (pready === 1'b1) break;
        end
        if (n >= 20) begin
            miscompares++;
            tally_and_finish();
        end
        last_q = prdata;
        last_e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clock);
    endtask

    task automatic frame();
        frame_start <= 1;
        @(posedge clock);
        frame_start <= 0;
        @(posedge clock);
    endtask

    function automatic mwf_ovl_e prio(input mwf_ovl_en_s en, input logic on);
        if (en.transparent && on) return MWF_OVL_TRANSPARENT;
        if (en.average) return MWF_OVL_AVERAGE;
        if (en.and_key) return MWF_OVL_AND_KEY;
        if (en.or_key) return MWF_OVL_OR_KEY;
        if (en.invert) return MWF_OVL_INVERT;
        return MWF_OVL_NONE;
    endfunction

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        apb(0, A_KEY, 0); check(last_q, 32'h0000_0000);
        check(last_e, 1'b0);
        apb(0, A_SAL, 0); check(last_q, 32'h0000_0000);
        apb(0, A_SAH, 0); check(last_q, 32'h0000_0000);
        apb(0, A_ST, 0); check(last_q, 32'h0000_0001);
        apb(0, A_LO, 0); check(last_q, 32'h0000_0000);
    endtask

    task automatic t_key();
        apb(1, A_KEY, 32'hffff_ffff);
        apb(0, A_KEY, 0); check(last_q, 32'h0000_00ff);
        check(key_blue, 8'hff);
        apb(1, A_KEY, 32'h0000_5a5a);
        check(key_blue, 8'h5a);
        // 5-bit blue 10101b widened by repeating its top bits
        apb(1, A_KEY, 32'h0000_00ad);
        check(key_blue, 8'had);
    endtask

    // every mode against every combination of enables
    task automatic t_overlay();
        for (int m = 0; m < 4; m++) begin
            for (int i = 0; i < 32; i++) begin
                overlay_window_mode <= m[1:0];
                overlay_en <= i[4:0];
                @(posedge clock);
                check(key_blue_active, (m == 3));
                check(overlay_function, prio(i[4:0], m == 3));
            end
        end
    endtask

    task automatic t_start();
        apb(1, A_SAL, 32'hffff_1234); // even step
        apb(1, A_SAH, 32'h0000_ffff);
        apb(0, A_SAH, 0); check(last_q, 32'h0000_0007);
        apb(0, A_ST, 0); check(last_q, 32'h0000_0000);
        check(fetch_addr, 19'h0_0000);
        frame();
        check(fetch_addr, 19'h7_1234);
        apb(0, A_ST, 0); check(last_q, 32'h0000_0001);
        frame();
        apb(0, A_ST, 0); check(last_q, 32'h0000_0001);
        apb(1, A_ST, 32'h0000_0000); check(last_e, 1'b0);
        apb(0, A_ST, 0); check(last_q, 32'h0000_0001);
    endtask

    task automatic t_dbuf();
        double_buffer_en <= 1;
        main_is_front <= 1;
        show_back_buffer <= 1;
        frame();
        apb(0, A_ST, 0); check(last_q, 32'h0000_0000);
        apb(1, A_SAL, 32'h0000_0040);
        apb(0, A_ST, 0); check(last_q, 32'h0000_0000);
        show_back_buffer <= 0;
        frame();
        apb(0, A_ST, 0); check(last_q, 32'h0000_0001);
        check(fetch_addr, 19'h7_0040);
        // overlay window in front: status tracks address latching again
        main_is_front <= 0;
        apb(1, A_SAL, 32'h0000_0080);
        apb(0, A_ST, 0); check(last_q, 32'h0000_0000);
        frame();
        apb(0, A_ST, 0); check(last_q, 32'h0000_0001);
        double_buffer_en <= 0;
    endtask

    task automatic t_line();
        apb(1, A_LO, 32'h0000_3abc); // width times bpp/8
        apb(0, A_LO, 0); check(last_q, 32'h0000_3abc);
        check(line_offset, 12'habc);
        check(pixel_double_h, 1'b1);
        check(pixel_double_v, 1'b1);
        // doubled at 90 deg, 16 bpp, 160 lines high: start at height minus two
        rotation_sel <= 2'h1;
        apb(1, A_SAL, 32'h0000_009e);
        apb(1, A_SAH, 32'h0000_0000);
        frame();
        check(fetch_addr, 19'h0_009e);
        apb(1, A_LO, 32'h0000_2001);
        check(pixel_double_h, 1'b0);
        check(pixel_double_v, 1'b1);
        check(line_offset, 12'h001);
    endtask

    task automatic t_misc();
        for (int r = 0; r < 4; r++) begin
            rotation_sel <= r[1:0];
            @(posedge clock);
            check(rotation, r[1:0]);
        end
        // unmapped and unaligned places refuse and read zero
        apb(1, 12'h860, 32'h0000_ffff); check(last_e, 1'b1);
        apb(0, 12'h842, 0); check(last_e, 1'b1);
        check(last_q, 32'h0000_0000);
    endtask

    initial begin
        repeat (12) @(posedge clock);
        sys_rst <= 0;
        @(posedge clock);
        t_reset();
        t_key();
        t_overlay();
        t_start();
        t_dbuf();
        t_line();
        t_misc();
        tally_and_finish();
    end
endmodule
